//--- rx_status_consts.vh
// Constants for the receive descriptor status write-back block.
// Included by the design files; holds definitions only.
`ifndef RX_STATUS_CONSTS_VH
`define RX_STATUS_CONSTS_VH

// Status word bit positions
`define CRC_ERROR_BIT   1
`define DRIBBLE_BIT     2
`define PHY_RX_ERR_BIT  3
`define LATE_EVENT_BIT  6
`define TOO_LONG_BIT    7
`define LAST_DESC_BIT   8
`define FIRST_DESC_BIT  9
`define MULTICAST_BIT   10
`define RUNT_BIT        11
`define RX_ERR_SUM_BIT  15

// Frame length limits in bytes
`define MAX_FRAME_LEN   14'h0800
`define MIN_FRAME_LEN   14'h0040

// Register offsets
`define OFF_CTRL        4'h0
`define OFF_IRQ_STATUS  4'h1
`define OFF_IRQ_MASK    4'h2
`define OFF_LAST_STATUS 4'h3
`define OFF_DESC_COUNT  4'h4
`define OFF_HIST_BASE   4'h8

// Interrupt status bits
`define IRQ_WB_DONE     0
`define IRQ_FRAME_ERR   1

// Reset values
`define CTRL_RESET      1'b1
`define MASK_RESET      2'h0

// History memory depth (log2)
`define HIST_AW         2

`endif

//--- status_history_mem.v
// Small memory of recently written status words.
// Assumes one clock; read data appear one cycle after the read address.
`timescale 1ns/1ps
`include "rx_status_consts.vh"

module status_history_mem (
  // Clock
  input  wire                  ref_clk,
  // Write side
  input  wire                  wr_en,
  input  wire [`HIST_AW-1:0]   wr_addr,
  input  wire [31:0]           wr_data,
  // Read side
  input  wire [`HIST_AW-1:0]   rd_addr,
  output reg  [31:0]           rd_data
);

  reg [31:0] mem [0:(1<<`HIST_AW)-1];

  // No reset on the array; software reads only entries it knows are written
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // status_history_mem

//--- rx_desc_status_wb.v
// Forms the receive descriptor status word and writes it back to memory.
// Assumes the receive DMA reports frame facts and per-descriptor events
// on ref_clk; the bus-master write path answers with wb_done.
`timescale 1ns/1ps
`include "rx_status_consts.vh"

// Contract
// - Set bit 10 when the frame's destination is multicast.
// - Set bit 9 in the descriptor holding the frame's opening portion.
// - Set bit 8 in the descriptor holding the frame's closing portion.
// - A frame fitting one descriptor gets both bits 9 and 8.
// - Middle descriptors of a frame get neither bit 9 nor 8.
// - Set bit 7 when the frame is longer than 2048 bytes.
// - Set bit 6 on collision after 64 bytes past the delimiter.
// - Set bit 3 when the physical layer reports a receive error.
// - Set bit 2 when the frame has extra bits past the last octet.
// - Dribble alone with clear CRC error still means a good frame.
// - Dribble is invalid when late event or runt is set.
// - Set bit 1 when the frame check sequence mismatches.
// - Set bit 1 also on any physical-layer receive error.
// - Set summary error on CRC, late event, too long or runt.
// - Set bit 11 when the frame is shorter than 64 bytes.
module rx_desc_status_wb (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        nrst,
  // Receive DMA descriptor events
  input  wire        desc_data_stored,
  input  wire        desc_is_first,
  input  wire        desc_is_last,
  input  wire [31:0] desc_addr,
  // Frame facts, valid with the last descriptor
  input  wire [13:0] frame_len,
  input  wire        frame_multicast,
  input  wire        frame_late_coll,
  input  wire        frame_phy_err,
  input  wire        frame_dribble,
  input  wire        frame_crc_bad,
  // Bus-master write path
  output reg         wb_req,
  output reg  [31:0] wb_addr,
  output reg  [31:0] wb_data,
  input  wire        wb_done,
  output wire        status_busy,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Interrupt
  output wire        irq
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg        state;
  reg        enable;
  reg [1:0]  irq_status;
  reg [1:0]  irq_mask;
  reg [31:0] last_status;
  reg [15:0] desc_count;
  reg [`HIST_AW-1:0] hist_ptr;
  reg        rd_hist;
  reg        rd_pend;
  reg [31:0] rd_reg;
  wire [31:0] hist_rdata;

  // Middle descriptors can carry no frame flags: the frame is not yet known
  wire first_d = desc_is_first;
  wire last_d  = desc_is_last;
  wire edge_d  = first_d | last_d;

  wire runt     = (frame_len < `MIN_FRAME_LEN);
  wire too_long = (frame_len > `MAX_FRAME_LEN);
  wire crc_err  = frame_crc_bad | frame_phy_err;
  // Dribble is suppressed where it cannot be trusted
  wire dribble  = frame_dribble & ~frame_late_coll & ~runt;
  // Dribble never feeds the summary, so such a frame stays good
  wire err_sum  = crc_err | frame_late_coll | too_long | runt;

  reg [31:0] next_status;
  always @* begin
    next_status = 32'h0;
    next_status[`FIRST_DESC_BIT] = first_d;
    next_status[`LAST_DESC_BIT]  = last_d;
    // Frame facts exist only once the frame has ended: last descriptor
    if (edge_d & last_d) begin
      next_status[`MULTICAST_BIT]  = frame_multicast;
      next_status[`TOO_LONG_BIT]   = too_long;
      next_status[`LATE_EVENT_BIT] = frame_late_coll;
      next_status[`PHY_RX_ERR_BIT] = frame_phy_err;
      next_status[`DRIBBLE_BIT]    = dribble;
      next_status[`CRC_ERROR_BIT]  = crc_err;
      next_status[`RUNT_BIT]       = runt;
      next_status[`RX_ERR_SUM_BIT] = err_sum;
    end
  end

  assign status_busy = (state == ST_WAIT);

  wire start   = enable & desc_data_stored & (state == ST_IDLE);
  wire done_ev = (state == ST_WAIT) & wb_done;

  // Write-back sequencer; one descriptor in flight, busy tells DMA to hold
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state      <= ST_IDLE;
      wb_req     <= 1'b0;
      wb_addr    <= 32'h0;
      wb_data    <= 32'h0;
      desc_count <= 16'h0;
      hist_ptr   <= {`HIST_AW{1'b0}};
      last_status <= 32'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            wb_req  <= 1'b1;
            wb_addr <= desc_addr;
            wb_data <= next_status;
            state   <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wb_done) begin
            wb_req      <= 1'b0;
            last_status <= wb_data;
            desc_count  <= desc_count + 16'h1;
            hist_ptr    <= hist_ptr + {{(`HIST_AW-1){1'b0}}, 1'b1};
            state       <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  status_history_mem u_hist (
    .ref_clk (ref_clk),
    .wr_en   (done_ev),
    .wr_addr (hist_ptr),
    .wr_data (wb_data),
    .rd_addr (reg_addr[`HIST_AW-1:0]),
    .rd_data (hist_rdata)
  );

  wire frame_err_ev = done_ev & wb_data[`RX_ERR_SUM_BIT];
  wire clr_wr = reg_wr & (reg_addr == `OFF_IRQ_STATUS);

  // Sticky status; a new event beats a same-cycle write-one clear
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      enable     <= `CTRL_RESET;
      irq_mask   <= `MASK_RESET;
      irq_status <= 2'h0;
    end else begin
      if (reg_wr & (reg_addr == `OFF_CTRL)) begin
        enable <= reg_wdata[0];
      end
      if (reg_wr & (reg_addr == `OFF_IRQ_MASK)) begin
        irq_mask <= reg_wdata[1:0];
      end
      irq_status[`IRQ_WB_DONE] <= done_ev |
        (irq_status[`IRQ_WB_DONE] & ~(clr_wr & reg_wdata[`IRQ_WB_DONE]));
      irq_status[`IRQ_FRAME_ERR] <= frame_err_ev |
        (irq_status[`IRQ_FRAME_ERR] &
         ~(clr_wr & reg_wdata[`IRQ_FRAME_ERR]));
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read mux; history words come from the memory's own output register
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_reg  <= 32'h0;
      rd_hist <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= reg_rd;
      rd_hist <= reg_rd & reg_addr[3];
      case (reg_addr)
        `OFF_CTRL:        rd_reg <= {31'h0, enable};
        `OFF_IRQ_STATUS:  rd_reg <= {30'h0, irq_status};
        `OFF_IRQ_MASK:    rd_reg <= {30'h0, irq_mask};
        `OFF_LAST_STATUS: rd_reg <= last_status;
        `OFF_DESC_COUNT:  rd_reg <= {16'h0, desc_count};
        default:          rd_reg <= 32'h0;
      endcase
    end
  end

  always @* begin
    if (!rd_pend) begin
      reg_rdata = 32'h0;
    end else if (rd_hist) begin
      reg_rdata = hist_rdata;
    end else begin
      reg_rdata = rd_reg;
    end
  end

endmodule // rx_desc_status_wb

//--- host_mem_model.sv
// Host memory side of the status write path.
// Assumes wb_req holds until wb_done has been seen.
`timescale 1ns/1ps
module host_mem_model (
  // Clock
  input  wire        ref_clk,
  // Write path
  input  wire        wb_req,
  input  wire [31:0] wb_data,
  input  wire [3:0]  lat,
  output reg         wb_done,
  output reg  [31:0] last_word
);
  reg [3:0] cnt = 4'h0;
  initial wb_done = 1'b0;
  // Lat cycles of wait model a slow memory
  always @(posedge ref_clk) begin
    wb_done <= 1'b0;
    if (wb_req && !wb_done) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lat) begin
        wb_done <= 1'b1;
        last_word <= wb_data;
        cnt <= 4'h0;
      end
    end
  end
endmodule // host_mem_model

//--- rx_desc_status_wb_assertions.sv
// Checker for the status write-back block.
// Assumes one clock ref_clk and reset nrst.
`timescale 1ns/1ps
module rx_desc_status_wb_assertions (
  // Clock and reset
  input wire        ref_clk,
  input wire        nrst,
  // Descriptor events
  input wire        desc_data_stored,
  input wire        desc_is_first,
  input wire        desc_is_last,
  input wire [13:0] frame_len,
  input wire        frame_phy_err,
  input wire        frame_crc_bad,
  // Write path
  input wire        wb_req,
  input wire [31:0] wb_data
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_first; $rose(wb_req) |->
    wb_data[9] == $past(desc_is_first); endproperty
  a_first: assert property (p_first) else $error("first");
  property p_last; $rose(wb_req) |->
    wb_data[8] == $past(desc_is_last); endproperty
  a_last: assert property (p_last) else $error("last");
  property p_long; $rose(wb_req) |->
    wb_data[7] == $past(desc_is_last && frame_len > 14'h0800); endproperty
  a_long: assert property (p_long) else $error("long");
  property p_runt; $rose(wb_req) |->
    wb_data[11] == $past(desc_is_last && frame_len < 14'h0040); endproperty
  a_runt: assert property (p_runt) else $error("runt");
  property p_crc; $rose(wb_req) |-> wb_data[1] ==
    $past(desc_is_last & (frame_crc_bad | frame_phy_err)); endproperty
  a_crc: assert property (p_crc) else $error("crc");
  property p_sum; wb_req |-> wb_data[15] ==
    (wb_data[1] | wb_data[6] | wb_data[7] | wb_data[11]); endproperty
  a_sum: assert property (p_sum) else $error("summary");
  property p_drb; wb_req && (wb_data[6] || wb_data[11]) |->
    !wb_data[2]; endproperty
  a_drb: assert property (p_drb) else $error("dribble");
  property p_go; $rose(wb_req) |-> $past(desc_data_stored); endproperty
  a_go: assert property (p_go) else $error("early write");
  c_one: cover property ($rose(wb_req) && wb_data[9] && wb_data[8]);
  c_mid: cover property ($rose(wb_req) && wb_data[9:8] == 2'h0);
  c_runt: cover property (wb_req && wb_data[11]);
endmodule // rx_desc_status_wb_assertions

//--- rx_desc_status_wb_tb.sv
// Self-checking bench for the status write-back block.
// Assumes the host memory model answers every write.
`timescale 1ns/1ps
`define CHK(n,e,g) begin checks_done++; if ((g) !== (e)) begin \
  $display("mismatch %s exp %h got %h", n, e, g); err_count++; end end
module rx_desc_status_wb_tb;
  reg         ref_clk = 1'b0;
  reg         nrst = 1'b0;
  reg         desc_data_stored = 1'b0;
  reg         desc_is_first = 1'b0;
  reg         desc_is_last = 1'b0;
  reg  [31:0] desc_addr = 32'h0;
  reg  [13:0] frame_len = 14'h0;
  reg  [4:0]  fl = 5'h0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [3:0]  lat = 4'h0;
  reg  [31:0] rdv;
  wire        wb_req, wb_done, status_busy, irq;
  wire [31:0] wb_addr, wb_data, reg_rdata, last_word;
  integer     err_count = 0;
  integer     checks_done = 0;
  rx_desc_status_wb u_rx_desc_status_wb (
    .ref_clk(ref_clk), .nrst(nrst), .desc_data_stored(desc_data_stored),
    .desc_is_first(desc_is_first), .desc_is_last(desc_is_last),
    .desc_addr(desc_addr), .frame_len(frame_len), .frame_multicast(fl[4]),
    .frame_late_coll(fl[3]), .frame_phy_err(fl[2]),
    .frame_dribble(fl[1]), .frame_crc_bad(fl[0]), .wb_req(wb_req),
    .wb_addr(wb_addr), .wb_data(wb_data), .wb_done(wb_done),
    .status_busy(status_busy), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  host_mem_model u_host_mem_model (.ref_clk(ref_clk), .wb_req(wb_req),
    .wb_data(wb_data), .lat(lat), .wb_done(wb_done), .last_word(last_word));
  initial forever #50 ref_clk = ~ref_clk;
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // Frame flags live only in the last descriptor
  function [31:0] expw(input f, input l, input [13:0] n, input [4:0] x);
    reg r, t, e;
    begin
      r = l && n < 14'h0040;
      t = l && n > 14'h0800;
      e = l && (x[0] || x[2]);
      expw = {16'h0, e | x[3] & l | t | r, 3'h0, r, l & x[4], f, l, t,
              l & x[3], 2'h0, l & x[2], l & x[1] & !x[3] & !r, e, 1'b0};
    end
  endfunction
  task desc(input f, input l, input [13:0] n, input [4:0] x);
    integer i;
    begin
      @(posedge ref_clk);
      desc_is_first <= f;
      desc_is_last <= l;
      frame_len <= n;
      fl <= x;
      desc_addr <= {18'h0, n};
      desc_data_stored <= 1'b1;
      @(posedge ref_clk);
      desc_data_stored <= 1'b0;
      for (i = 0; i < 30 && wb_done !== 1'b1; i = i + 1)
        @(posedge ref_clk) #1;
      if (i == 30) begin
        err_count++;
        conclude;
      end
      `CHK("busy", 1'b1, status_busy)
      @(posedge ref_clk);
      `CHK("word", expw(f, l, n, x), last_word)
      `CHK("addr", {18'h0, n}, wb_addr)
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 rdv = reg_rdata;
    end
  endtask
  task t_frames;
    begin
      desc(1'b1, 1'b1, 14'h0064, 5'h10);
      desc(1'b1, 1'b0, 14'h0000, 5'h1f);
      desc(1'b0, 1'b0, 14'h0000, 5'h1f);
      desc(1'b0, 1'b1, 14'h0bb8, 5'h00);
      $display("frames done");
    end
  endtask
  task t_lens;
    begin
      desc(1'b1, 1'b1, 14'h003f, 5'h02);
      desc(1'b1, 1'b1, 14'h0040, 5'h00);
      desc(1'b1, 1'b1, 14'h0800, 5'h00);
      desc(1'b1, 1'b1, 14'h0801, 5'h00);
      $display("lengths done");
    end
  endtask
  task t_errs;
    begin
      lat <= 4'h3;
      desc(1'b1, 1'b1, 14'h0100, 5'h0a);
      desc(1'b1, 1'b1, 14'h0100, 5'h04);
      desc(1'b1, 1'b1, 14'h0100, 5'h02);
      desc(1'b1, 1'b1, 14'h0100, 5'h01);
      $display("errors done");
    end
  endtask
  task t_irq;
    begin
      bus(1'b0, 4'h0, 32'h0);
      `CHK("ctrl", 32'h1, rdv)
      bus(1'b0, 4'h1, 32'h0);
      `CHK("status", 32'h3, rdv)
      `CHK("irq off", 1'b0, irq)
      bus(1'b1, 4'h2, 32'h3);
      `CHK("irq on", 1'b1, irq)
      bus(1'b1, 4'h1, 32'h3);
      `CHK("irq clr", 1'b0, irq)
      bus(1'b0, 4'h7, 32'h0);
      `CHK("unmapped", 32'h0, rdv)
      bus(1'b0, 4'h3, 32'h0);
      `CHK("last", 32'h00008302, rdv)
      bus(1'b0, 4'h4, 32'h0);
      `CHK("count", 32'h0000000c, rdv)
      bus(1'b0, 4'hb, 32'h0);
      `CHK("history", 32'h00008302, rdv)
      $display("interrupt done");
    end
  endtask
  // Disabled block must ignore a stored-data pulse
  task t_off;
    integer i;
    begin
      bus(1'b1, 4'h0, 32'h0);
      @(posedge ref_clk);
      desc_data_stored <= 1'b1;
      @(posedge ref_clk);
      desc_data_stored <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        @(posedge ref_clk) #1;
      `CHK("off req", 1'b0, wb_req)
      bus(1'b1, 4'h0, 32'h1);
      $display("disable done");
    end
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    t_frames;
    t_lens;
    t_errs;
    t_irq;
    t_off;
    conclude;
  end
endmodule // rx_desc_status_wb_tb
bind rx_desc_status_wb rx_desc_status_wb_assertions
  u_rx_desc_status_wb_assertions (.ref_clk(ref_clk), .nrst(nrst),
  .desc_data_stored(desc_data_stored), .desc_is_first(desc_is_first),
  .desc_is_last(desc_is_last), .frame_len(frame_len),
  .frame_phy_err(frame_phy_err), .frame_crc_bad(frame_crc_bad),
  .wb_req(wb_req), .wb_data(wb_data));
